// File: bench/b4s_link_props.sv
// concurrent checks on the sram link between the two ends
`timescale 1ns/1ps
module b4s_link_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire b4s_pkg::b4s_word_type q_true,
	input wire b4s_pkg::b4s_word_type q_comp,
	input wire logic q_oe
);
	import b4s_pkg::*;
	logic rd_prev_reg;
	logic rd_take;
	// a select low right after a taken read is ignored
	assign rd_take = !read_port_select_n && !rd_prev_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_prev_reg <= 1'b0;
		end else begin
			rd_prev_reg <= rd_take;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence rd_start; rd_take; endsequence
	sequence rd_beats; q_oe [*2]; endsequence
	sequence rd_lone; rd_take ##1 !rd_take ##1 !rd_take; endsequence
	rd_beats_a: assert property (rd_start |-> ##3 rd_beats)
		else $error("read bus not driven for both beats");
	oe_release_a: assert property (rd_lone |-> ##3 !q_oe)
		else $error("read bus held after burst");
	oe_cause_a: assert property (q_oe |-> $past(rd_take, 3) || $past(rd_take, 4))
		else $error("read bus driven without a read");
	oe_hold_a: assert property ($rose(q_oe) |=> q_oe)
		else $error("read bus driven for one cycle only");
	idle_bus_a: assert property (!q_oe |-> q_true == '0 && q_comp == '0)
		else $error("read data shown while bus is off");
	nop_quiet_a: assert property (read_port_select_n [*5] |-> !q_oe)
		else $error("read bus driven while deselected");
	rd_space_a: assert property (!read_port_select_n |=> read_port_select_n)
		else $error("reads started on consecutive cycles");
	wr_space_a: assert property (!write_port_select_n |=> write_port_select_n)
		else $error("writes started on consecutive cycles");
endmodule : b4s_link_props

// File: bench/tb_burst4_split_port_sram_cmd.sv
// self-checking bench: controller end drives device end; x8 and x9 device ends face the bench
`timescale 1ns/1ps
module tb_burst4_split_port_sram_cmd;
	import b4s_pkg::*;
	logic clk = 0, rstn = 0, cmd_valid = 0, full_seen = 0;
	logic rs, ws, rd_valid, cmd_ready;
	b4s_cmd_type cmd = '0;
	b4s_burst_type rd_data;
	b4s_word_type mem [16];
	b4s_burst_type exp_q [$];
	int error_cnt = 0, comparisons = 0, n = 0;
	// {read sel, write sel, read taken, write taken}
	logic [3:0] vec [10] = '{4'h6, 4'h4, 4'hC, 4'h9, 4'h8, 4'hC, 4'h2, 4'h1, 4'h2, 4'hC};
	always #50 clk = ~clk;
	b4s_link_if link (.clk(clk), .rstn(rstn));
	b4s_link_if link2 (.clk(clk), .rstn(rstn));
	b4s_mem_end b4s_mem_end_i (.link(link), .read_started(), .write_started());
	b4s_link_if link3 (.clk(clk), .rstn(rstn));
	b4s_mem_end #(.CFG(B4S_X8)) b4s_mem_end_fault_i (.link(link2), .read_started(rs), .write_started(ws));
	b4s_mem_end #(.CFG(B4S_X9)) b4s_mem_end_x9_i (.link(link3), .read_started(), .write_started());
	// the x9 end sees every pin that the bench drives on the x8 end
	assign link3.addr = link2.addr;
	assign link3.read_port_select_n = link2.read_port_select_n;
	assign link3.write_port_select_n = link2.write_port_select_n;
	assign link3.d_true = link2.d_true;
	assign link3.d_comp = link2.d_comp;
	assign link3.byte_write_select_n_true = link2.byte_write_select_n_true;
	assign link3.byte_write_select_n_comp = link2.byte_write_select_n_comp;
	b4s_ctrl_end b4s_ctrl_end_i (.link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.rd_valid(rd_valid), .rd_data(rd_data));
	b4s_link_props b4s_link_props_i (.clk(clk), .rstn(rstn), .read_port_select_n(link.read_port_select_n),
		.write_port_select_n(link.write_port_select_n), .q_true(link.q_true), .q_comp(link.q_comp), .q_oe(link.q_oe));
	task automatic check(input string name, input b4s_burst_type e, input b4s_burst_type g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic check_bit(input string name, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %b seen %b", name, e, g);
		end
	endtask : check_bit
	function automatic b4s_word_type lanes(b4s_sel_type s);
		return {{9{!s[1]}}, {9{!s[0]}}};
	endfunction : lanes
	always @(posedge clk) begin
		if (cmd_valid === 1'b1 && cmd_ready === 1'b0) full_seen = 1'b1;
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) check_bit("unexpected burst", 1'b0, 1'b1);
			else check("read burst", exp_q.pop_front(), rd_data);
		end
	end
	// entered at a rising edge; leaves the request up for a following push
	task automatic push(input logic w, input b4s_addr_type a, input logic [7:0] sel);
		b4s_cmd_type c;
		b4s_burst_type b;
		int k;
		c.is_write = w;
		c.addr = a;
		for (k = 0; k < 4; k++) begin
			c.data[k] = 18'h2A5A5 ^ b4s_word_type'(n + k);
			c.sel_n[k] = sel[2*k +: 2];
		end
		cmd_valid <= 1'b1;
		cmd <= c;
		k = 0;
		do @(posedge clk); while (cmd_ready !== 1'b1 && ++k < 200);
		check_bit("command taken", 1'b1, cmd_ready);
		for (k = 0; k < 4; k++) begin
			b[k] = mem[a + 4'(k)];
			if (w) mem[a + 4'(k)] = (b[k] & ~lanes(c.sel_n[k])) | (c.data[k] & lanes(c.sel_n[k]));
		end
		if (!w) exp_q.push_back(b);
		n += 4;
	endtask : push
	task automatic drain;
		int k;
		k = 0;
		cmd_valid <= 1'b0;
		do @(posedge clk); while (exp_q.size() != 0 && ++k < 300);
		check_bit("bursts outstanding", 1'b1, exp_q.size() == 0);
	endtask : drain
	task automatic reset_idle;
		check_bit("read bus enable", 1'b0, link.q_oe);
		check_bit("read select", 1'b1, link.read_port_select_n);
		check_bit("write select", 1'b1, link.write_port_select_n);
		@(posedge clk);
	endtask : reset_idle
	// writes outrun the issuer, so the fifo fills and refuses
	task automatic fill_fifo;
		for (int i = 0; i < 40; i++) push(1'b1, b4s_addr_type'(i), 8'h00);
		check_bit("fifo refused", 1'b1, full_seen);
	endtask : fill_fifo
	task automatic read_all;
		for (int i = 0; i < 16; i++) push(1'b0, b4s_addr_type'(i), 8'h00);
		drain();
	endtask : read_all
	// wrapped burst, one lane pattern per beat, read right behind it
	task automatic lane_write;
		push(1'b1, 4'hE, 8'hD8);
		push(1'b0, 4'hE, 8'h00);
		push(1'b0, 4'hC, 8'h00);
		drain();
	endtask : lane_write
	task automatic fault_link;
		for (int k = 0; k < 12; k++) begin
			@(posedge clk);
			if (k >= 2) check_bit("read taken", vec[k-2][1], rs);
			if (k >= 2) check_bit("write taken", vec[k-2][0], ws);
			link2.read_port_select_n <= (k < 10) ? vec[k][3] : 1'b1;
			link2.write_port_select_n <= (k < 10) ? vec[k][2] : 1'b1;
		end
		repeat (4) @(posedge clk);
		check_bit("idle read bus", 1'b0, link2.q_oe);
	endtask : fault_link
	// one burst at 3 with beat selects 00, 01, 10, 11, read back on both narrow ends
	task automatic narrow_lanes;
		b4s_burst_type g8;
		b4s_burst_type g9;
		link2.addr <= 4'h3;
		link2.write_port_select_n <= 1'b0;
		@(posedge clk);
		link2.write_port_select_n <= 1'b1;
		link2.d_true <= 18'h3FFFF;
		link2.d_comp <= 18'h3FFFF;
		link2.byte_write_select_n_true <= 2'h0;
		link2.byte_write_select_n_comp <= 2'h1;
		@(posedge clk);
		link2.byte_write_select_n_true <= 2'h2;
		link2.byte_write_select_n_comp <= 2'h3;
		@(posedge clk);
		link2.read_port_select_n <= 1'b0;
		link2.d_true <= '0;
		link2.d_comp <= '0;
		link2.byte_write_select_n_true <= '1;
		link2.byte_write_select_n_comp <= '1;
		@(posedge clk);
		link2.read_port_select_n <= 1'b1;
		repeat (3) @(posedge clk);
		g8[0] = link2.q_true;
		g8[1] = link2.q_comp;
		g9[0] = link3.q_true;
		g9[1] = link3.q_comp;
		@(posedge clk);
		g8[2] = link2.q_true;
		g8[3] = link2.q_comp;
		g9[2] = link3.q_true;
		g9[3] = link3.q_comp;
		check("x8 nibble lanes", {18'h00000, 18'h0000F, 18'h000F0, 18'h000FF}, g8);
		check("x9 byte lane", {18'h00000, 18'h001FF, 18'h00000, 18'h001FF}, g9);
	endtask : narrow_lanes
	task automatic complete_run;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		link2.addr = '0;
		link2.read_port_select_n = 1'b1;
		link2.write_port_select_n = 1'b1;
		link2.d_true = '0;
		link2.d_comp = '0;
		link2.byte_write_select_n_true = '1;
		link2.byte_write_select_n_comp = '1;
		foreach (mem[i]) mem[i] = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		reset_idle();
		fill_fifo();
		read_all();
		lane_write();
		fault_link();
		narrow_lanes();
		complete_run();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule : tb_burst4_split_port_sram_cmd

// File: hdl/b4s_ctrl_end.sv
// controller end: command fifo and the burst issuer that drives the sram link
`timescale 1ns/1ps
`include "b4s_defs.svh"
module b4s_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `B4S_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// depth must be a power of two: pointers wrap by overflow
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] count;
		logic ready;
	} b4s_fifo_state_type;

	b4s_fifo_state_type s_reg;
	b4s_fifo_state_type s_next;
	logic push;
	logic pop;

	always_comb begin
		s_next = s_reg;
		push = in_valid && s_reg.ready;
		pop = out_ready && (s_reg.count != '0);
		if (push) begin
			s_next.mem[s_reg.wp] = in_data;
			s_next.wp = s_reg.wp + 1'b1;
		end
		if (pop) begin
			s_next.rp = s_reg.rp + 1'b1;
		end
		s_next.count = s_reg.count + (AW+1)'(push) - (AW+1)'(pop);
		// ready is registered so the port comes from a flop; costs one cycle after reset
		s_next.ready = s_next.count != (AW+1)'(DEPTH);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign in_ready = s_reg.ready;
	assign out_valid = s_reg.count != '0;
	assign out_data = s_reg.mem[s_reg.rp];
endmodule : b4s_fifo

module b4s_ctrl_end (
	b4s_link_if.ctrl link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire b4s_pkg::b4s_cmd_type cmd,
	output logic rd_valid,
	output b4s_pkg::b4s_burst_type rd_data
);
	import b4s_pkg::*;

	typedef struct packed {
		b4s_addr_type addr;
		logic rps_n;
		logic wps_n;
		b4s_word_type d_true;
		b4s_word_type d_comp;
		b4s_sel_type sel_t;
		b4s_sel_type sel_c;
		b4s_wphase_type wph;
		b4s_burst_type wdata;
		b4s_sel_type [`B4S_BURST-1:0] wsel;
		logic [`B4S_RD_AGE_W-1:0] rd_age;
		b4s_burst_type rd_data;
		logic rd_valid;
	} b4s_ctrl_state_type;

	localparam b4s_ctrl_state_type CTRL_RST = '{rps_n: 1'b1, wps_n: 1'b1, sel_t: '1, sel_c: '1,
		wph: B4S_WIDLE, default: '0};

	b4s_ctrl_state_type s_reg;
	b4s_ctrl_state_type s_next;
	logic head_valid;
	b4s_cmd_type head;
	logic pop;

	b4s_fifo #(
		.WIDTH($bits(b4s_cmd_type)),
		.DEPTH(`B4S_FIFO_DEPTH)
	) u_cmd_fifo (
		.clk(link.clk),
		.rstn(link.rstn),
		.in_valid(cmd_valid),
		.in_ready(cmd_ready),
		.in_data(cmd),
		.out_valid(head_valid),
		.out_ready(pop),
		.out_data(head)
	);

	always_comb begin
		s_next = s_reg;
		// a select driven low now is sampled at the next edge; never two same-type in a row
		pop = head_valid && (head.is_write ? s_reg.wps_n : s_reg.rps_n);
		s_next.rps_n = 1'b1;
		s_next.wps_n = 1'b1;
		s_next.d_true = '0;
		s_next.d_comp = '0;
		s_next.sel_t = '1;
		s_next.sel_c = '1;
		case (s_reg.wph)
			B4S_WFIRST: begin
				s_next.d_true = s_reg.wdata[0];
				s_next.d_comp = s_reg.wdata[1];
				s_next.sel_t = s_reg.wsel[0];
				s_next.sel_c = s_reg.wsel[1];
				s_next.wph = B4S_WSECOND;
			end
			B4S_WSECOND: begin
				s_next.d_true = s_reg.wdata[2];
				s_next.d_comp = s_reg.wdata[3];
				s_next.sel_t = s_reg.wsel[2];
				s_next.sel_c = s_reg.wsel[3];
				s_next.wph = B4S_WIDLE;
			end
			default: begin
				s_next.wph = B4S_WIDLE;
			end
		endcase
		if (pop) begin
			s_next.addr = head.addr;
			if (head.is_write) begin
				s_next.wps_n = 1'b0;
				s_next.wdata = head.data;
				s_next.wsel = head.sel_n;
				s_next.wph = B4S_WFIRST;
			end else begin
				s_next.rps_n = 1'b0;
			end
		end
		// age 0 is the issue edge; the device is one edge behind, data two more
		s_next.rd_age = {s_reg.rd_age[`B4S_RD_AGE_W-2:0], pop && !head.is_write};
		if (s_reg.rd_age[`B4S_RD_FIRST_AGE]) begin
			s_next.rd_data[0] = link.q_true;
			s_next.rd_data[1] = link.q_comp;
		end
		if (s_reg.rd_age[`B4S_RD_LAST_AGE]) begin
			s_next.rd_data[2] = link.q_true;
			s_next.rd_data[3] = link.q_comp;
		end
		s_next.rd_valid = s_reg.rd_age[`B4S_RD_LAST_AGE];
	end

	always_ff @(posedge link.clk or negedge link.rstn) begin
		if (!link.rstn) begin
			s_reg <= CTRL_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.addr = s_reg.addr;
	assign link.read_port_select_n = s_reg.rps_n;
	assign link.write_port_select_n = s_reg.wps_n;
	assign link.d_true = s_reg.d_true;
	assign link.d_comp = s_reg.d_comp;
	assign link.byte_write_select_n_true = s_reg.sel_t;
	assign link.byte_write_select_n_comp = s_reg.sel_c;
	assign rd_valid = s_reg.rd_valid;
	assign rd_data = s_reg.rd_data;
endmodule : b4s_ctrl_end

// File: hdl/b4s_defs.svh
// constants for the four-word burst split-port sram link
`ifndef B4S_DEFS_SVH
`define B4S_DEFS_SVH
`define B4S_WORD_W 18
`define B4S_ADDR_W 4
`define B4S_MEM_DEPTH 16
`define B4S_SEL_W 2
`define B4S_BURST 4
`define B4S_NIB_W 4
`define B4S_BYTE_W 9
`define B4S_FIFO_DEPTH 16
`define B4S_CLK_PERIOD_NS 100
`define B4S_RD_AGE_W 5
`define B4S_RD_FIRST_AGE 3
`define B4S_RD_LAST_AGE 4
`endif

// File: hdl/b4s_link_if.sv
// link between the sram device end and its controller end
`timescale 1ns/1ps
interface b4s_link_if (
	input wire logic clk,
	input wire logic rstn
);
	import b4s_pkg::*;
	b4s_addr_type addr;
	logic read_port_select_n;
	logic write_port_select_n;
	b4s_word_type d_true;
	b4s_word_type d_comp;
	b4s_sel_type byte_write_select_n_true;
	b4s_sel_type byte_write_select_n_comp;
	b4s_word_type q_true;
	b4s_word_type q_comp;
	logic q_oe;

	modport mem (
		input clk,
		input rstn,
		input addr,
		input read_port_select_n,
		input write_port_select_n,
		input d_true,
		input d_comp,
		input byte_write_select_n_true,
		input byte_write_select_n_comp,
		output q_true,
		output q_comp,
		output q_oe
	);

	modport ctrl (
		input clk,
		input rstn,
		output addr,
		output read_port_select_n,
		output write_port_select_n,
		output d_true,
		output d_comp,
		output byte_write_select_n_true,
		output byte_write_select_n_comp,
		input q_true,
		input q_comp,
		input q_oe
	);
endinterface : b4s_link_if

// File: hdl/b4s_mem_end.sv
// sram device end: four-word bursts, split read and write ports, shared address
// How it works
// - write starts on write select low, read select high
// - write words taken true/comp of t+1, t+2
// - read words driven true/comp of t+2, t+3
// - burst words go to A, A+1, A+2, A+3
// - data taken and launched on both phases
// - after reset both ports idle, read bus off
// - controller spaces same-type starts two cycles apart
// - same-type start right after one is ignored
// - select low last start cycle is don't-care
// - controller holds both phases high when stopped
// - x8: select 0 bits 3:0, 1 bits 7:4
// - x9: single select gates bits 8:0
// - lane selects sampled per beat; all high writes nothing
// - both selects from idle: read first, then alternate
// - bursts last two cycles; selects sampled on true phase
`timescale 1ns/1ps
`include "b4s_defs.svh"
module b4s_mem_end #(
	parameter b4s_pkg::b4s_cfg_type CFG = b4s_pkg::B4S_X18
) (
	b4s_link_if.mem link,
	output logic read_started,
	output logic write_started
);
	import b4s_pkg::*;

	// one true/comp phase pair per clk: the _true and _comp lanes carry the two ddr beats
	typedef struct packed {
		b4s_word_type [`B4S_MEM_DEPTH-1:0] mem;
		logic rd1_v;
		logic rd2_v;
		logic rd3_v;
		b4s_addr_type rd1_a;
		b4s_addr_type rd2_a;
		b4s_addr_type rd3_a;
		logic wr1_v;
		logic wr2_v;
		b4s_addr_type wr1_a;
		b4s_addr_type wr2_a;
		b4s_word_type q_true;
		b4s_word_type q_comp;
		logic q_oe;
	} b4s_mem_state_type;

	b4s_mem_state_type s_reg;
	b4s_mem_state_type s_next;
	logic rd_go;
	logic wr_go;
	b4s_addr_type wbase;
	b4s_addr_type rbase;

	always_comb begin
		s_next = s_reg;
		wbase = s_reg.wr1_v ? s_reg.wr1_a : s_reg.wr2_a;
		rbase = s_reg.rd2_v ? s_reg.rd2_a : s_reg.rd3_a;
		// a read started last cycle masks the read select now
		rd_go = !link.read_port_select_n && !s_reg.rd1_v;
		// reads win a tie unless one began last cycle, so ties alternate
		wr_go = !link.write_port_select_n && !s_reg.wr1_v && !rd_go;
		s_next.rd1_v = rd_go;
		s_next.rd1_a = link.addr;
		s_next.rd2_v = s_reg.rd1_v;
		s_next.rd2_a = s_reg.rd1_a;
		s_next.rd3_v = s_reg.rd2_v;
		s_next.rd3_a = s_reg.rd2_a;
		s_next.wr1_v = wr_go;
		s_next.wr1_a = link.addr;
		s_next.wr2_v = s_reg.wr1_v;
		s_next.wr2_a = s_reg.wr1_a;
		// beats A,A+1 on t+1, A+2,A+3 on t+2; masks apply per beat
		if (s_reg.wr1_v || s_reg.wr2_v) begin
			s_next.mem[b4s_addr_plus(wbase, {s_reg.wr2_v, 1'b0})] = b4s_merge(
				s_reg.mem[b4s_addr_plus(wbase, {s_reg.wr2_v, 1'b0})], link.d_true,
				b4s_lane_mask(CFG, link.byte_write_select_n_true));
			s_next.mem[b4s_addr_plus(wbase, {s_reg.wr2_v, 1'b1})] = b4s_merge(
				s_reg.mem[b4s_addr_plus(wbase, {s_reg.wr2_v, 1'b1})], link.d_comp,
				b4s_lane_mask(CFG, link.byte_write_select_n_comp));
		end
		// reading s_reg.mem here already holds every beat of a write begun a cycle earlier
		s_next.q_oe = s_reg.rd2_v || s_reg.rd3_v;
		s_next.q_true = s_next.q_oe ? s_reg.mem[b4s_addr_plus(rbase, {s_reg.rd3_v, 1'b0})] : '0;
		s_next.q_comp = s_next.q_oe ? s_reg.mem[b4s_addr_plus(rbase, {s_reg.rd3_v, 1'b1})] : '0;
	end

	always_ff @(posedge link.clk or negedge link.rstn) begin
		if (!link.rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.q_true = s_reg.q_true;
	assign link.q_comp = s_reg.q_comp;
	assign link.q_oe = s_reg.q_oe;
	assign read_started = s_reg.rd1_v;
	assign write_started = s_reg.wr1_v;
endmodule : b4s_mem_end

// File: hdl/b4s_pkg.sv
// types shared by both ends of the sram link, and helper functions used by the device end
`include "b4s_defs.svh"
package b4s_pkg;
	typedef logic [`B4S_WORD_W-1:0] b4s_word_type;
	typedef logic [`B4S_ADDR_W-1:0] b4s_addr_type;
	typedef logic [`B4S_SEL_W-1:0] b4s_sel_type;
	typedef b4s_word_type [`B4S_BURST-1:0] b4s_burst_type;
	typedef enum logic [1:0] {B4S_X8, B4S_X9, B4S_X18} b4s_cfg_type;
	typedef enum logic [1:0] {B4S_WIDLE, B4S_WFIRST, B4S_WSECOND} b4s_wphase_type;

	typedef struct packed {
		logic is_write;
		b4s_addr_type addr;
		b4s_burst_type data;
		b4s_sel_type [`B4S_BURST-1:0] sel_n;
	} b4s_cmd_type;

	function automatic b4s_addr_type b4s_addr_plus(b4s_addr_type a, logic [1:0] k);
		return b4s_addr_type'(a + b4s_addr_type'(k));
	endfunction : b4s_addr_plus

	// active-low lane selects to a mask of bits that get written
	function automatic b4s_word_type b4s_lane_mask(b4s_cfg_type cfg, b4s_sel_type sel_n);
		b4s_word_type m;
		m = '0;
		case (cfg)
			B4S_X8: begin
				if (!sel_n[0]) m[`B4S_NIB_W-1:0] = '1;
				if (!sel_n[1]) m[2*`B4S_NIB_W-1:`B4S_NIB_W] = '1;
			end
			B4S_X9: begin
				if (!sel_n[0]) m[`B4S_BYTE_W-1:0] = '1;
			end
			default: begin
				if (!sel_n[0]) m[`B4S_BYTE_W-1:0] = '1;
				if (!sel_n[1]) m[2*`B4S_BYTE_W-1:`B4S_BYTE_W] = '1;
			end
		endcase
		return m;
	endfunction : b4s_lane_mask

	function automatic b4s_word_type b4s_merge(b4s_word_type old, b4s_word_type d, b4s_word_type m);
		return (old & ~m) | (d & m);
	endfunction : b4s_merge
endpackage : b4s_pkg
